// [rtl/otl_otg_limit_regs.sv]
// output voltage and current limit register bank with checked writes
// Functional notes
// - voltage writes outside 3 V..20.8 V are dropped
// - add 1.28 V offset unless offset disable set
// - high byte 5:0 holds code 11:6
// - low byte 7:2 holds code 5:0
// - current code 6:0 at 09h, 50 mA steps
// - reserved high bits set means invalid write
// - ignore 06h bits 1:0 and all 08h
`timescale 1ns/10ps
module otl_otg_limit_regs
  import otl_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // byte register port
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic WR_REJECT_O,
  // offset select from the configuration bank
  input wire logic OFFSET_DIS_I,
  // limits toward the regulation loop
  output logic [VOLT_CODE_W-1:0] VOLT_CODE_O,
  output logic [VOLT_W-1:0] VOLT_DMV_O,
  output logic [CURR_CODE_W-1:0] CURR_CODE_O,
  output logic [CURR_MA_W-1:0] CURR_MA_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [VOLT_HALF_W-1:0] vlo_pend_ff, nxt_vlo_pend;
  logic [VOLT_CODE_W-1:0] volt_code_ff, nxt_volt_code;
  logic [CURR_CODE_W-1:0] curr_code_ff, nxt_curr_code;
  logic reject_ff, nxt_reject;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [VOLT_W-1:0] volt_dmv_ff, nxt_volt_dmv;
  logic [CURR_MA_W-1:0] curr_ma_ff, nxt_curr_ma;

  logic [VOLT_CODE_W-1:0] cand_code;
  logic [VOLT_W-1:0] cand_dmv;
  logic cand_in_range;
  logic vhi_rsv_ok;
  logic cand_ok;

  // ----------------------------------------------------------------
  // candidate check
  // ----------------------------------------------------------------
  // the low byte is only staged; the check waits for the high byte so
  // a half-written code never reaches the loop
  assign cand_code = {REG_WDATA_I[VOLT_HALF_W-1:0], vlo_pend_ff};

  otl_volt_sum u_cand_sum (
    .code_i(cand_code),
    .offset_dis_i(OFFSET_DIS_I),
    .dmv_o(cand_dmv)
  );

  assign cand_in_range = (cand_dmv >= VOLT_MIN_DMV) && (cand_dmv <= VOLT_MAX_DMV);
  assign vhi_rsv_ok = (REG_WDATA_I & VHI_RSV_MASK) == 8'h00;
  assign cand_ok = cand_in_range && vhi_rsv_ok;

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_vlo_pend = vlo_pend_ff;
    nxt_volt_code = volt_code_ff;
    nxt_curr_code = curr_code_ff;
    nxt_reject = 1'b0;
    if (REG_WR_I)
    begin
      case (REG_ADDR_I)
        ADDR_VLO:
        begin
          // bits 1:0 are dropped here
          nxt_vlo_pend = REG_WDATA_I[7:VLO_CODE_LSB];
        end
        ADDR_VHI:
        begin
          if (cand_ok)
          begin
            nxt_volt_code = cand_code;
          end
          else
          begin
            nxt_reject = 1'b1;
          end
        end
        ADDR_CHI:
        begin
          if ((REG_WDATA_I & CHI_RSV_MASK) == 8'h00)
          begin
            nxt_curr_code = REG_WDATA_I[CURR_CODE_W-1:0];
          end
          else
          begin
            nxt_reject = 1'b1;
          end
        end
        default:
        begin
          // 08h and unmapped bytes take no effect
          nxt_reject = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      vlo_pend_ff <= VOLT_HALF_RST;
      volt_code_ff <= {VOLT_HALF_RST, VOLT_HALF_RST};
      curr_code_ff <= CURR_CODE_RST;
      reject_ff <= 1'b0;
    end
    else
    begin
      vlo_pend_ff <= nxt_vlo_pend;
      volt_code_ff <= nxt_volt_code;
      curr_code_ff <= nxt_curr_code;
      reject_ff <= nxt_reject;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        ADDR_VLO: nxt_rdata = {volt_code_ff[VOLT_HALF_W-1:0], 2'b00};
        ADDR_VHI: nxt_rdata = {2'b00, volt_code_ff[VOLT_CODE_W-1:VOLT_HALF_W]};
        ADDR_CHI: nxt_rdata = {1'b0, curr_code_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      rdata_ff <= RDATA_RST;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // effective limits
  // ----------------------------------------------------------------
  // the offset select may move after a write; the level follows it, so a
  // stored code can sit outside the window once the offset is changed
  otl_volt_sum u_out_sum (
    .code_i(volt_code_ff),
    .offset_dis_i(OFFSET_DIS_I),
    .dmv_o(nxt_volt_dmv)
  );

  always_comb
  begin
    nxt_curr_ma = {6'h00, curr_code_ff} * CURR_STEP_MA;
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I)
  begin
    if (!ARST_N_I)
    begin
      volt_dmv_ff <= '0;
      curr_ma_ff <= '0;
    end
    else
    begin
      volt_dmv_ff <= nxt_volt_dmv;
      curr_ma_ff <= nxt_curr_ma;
    end
  end

  assign REG_RDATA_O = rdata_ff;
  assign WR_REJECT_O = reject_ff;
  assign VOLT_CODE_O = volt_code_ff;
  assign VOLT_DMV_O = volt_dmv_ff;
  assign CURR_CODE_O = curr_code_ff;
  assign CURR_MA_O = curr_ma_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  sequence s_low_wr;
    REG_WR_I && (REG_ADDR_I == ADDR_VLO);
  endsequence

  sequence s_high_ok;
    REG_WR_I && (REG_ADDR_I == ADDR_VHI) && cand_ok;
  endsequence

  property p_volt_reject;
    REG_WR_I && (REG_ADDR_I == ADDR_VHI) && !cand_in_range
      |=> $stable(volt_code_ff) && WR_REJECT_O;
  endproperty
  a_volt_reject: assert property (p_volt_reject) else $error("out of range write stored");

  property p_volt_accept;
    s_high_ok |=> (VOLT_CODE_O == {$past(REG_WDATA_I[5:0]), $past(vlo_pend_ff)})
      && !WR_REJECT_O;
  endproperty
  a_volt_accept: assert property (p_volt_accept) else $error("valid write not stored");

  property p_volt_offset;
    !OFFSET_DIS_I ##1 (OFFSET_DIS_I && $stable(volt_code_ff))
      |=> VOLT_W'($past(VOLT_DMV_O) - VOLT_DMV_O) == VOLT_OFFSET_DMV;
  endproperty
  a_volt_offset: assert property (p_volt_offset) else $error("offset step wrong");

  property p_vhi_read;
    REG_RD_I && (REG_ADDR_I == ADDR_VHI)
      |=> REG_RDATA_O == {2'b00, $past(volt_code_ff[11:6])};
  endproperty
  a_vhi_read: assert property (p_vhi_read) else $error("high byte readback wrong");

  property p_vlo_read;
    REG_RD_I && (REG_ADDR_I == ADDR_VLO)
      |=> REG_RDATA_O == {$past(volt_code_ff[5:0]), 2'b00};
  endproperty
  a_vlo_read: assert property (p_vlo_read) else $error("low byte readback wrong");

  property p_curr_scale;
    $changed(curr_code_ff) |=> CURR_MA_O == ({6'h00, $past(curr_code_ff)} * CURR_STEP_MA);
  endproperty
  a_curr_scale: assert property (p_curr_scale) else $error("current scale wrong");

  property p_chi_rsv;
    REG_WR_I && (REG_ADDR_I == ADDR_CHI) && REG_WDATA_I[7]
      |=> $stable(curr_code_ff) && WR_REJECT_O;
  endproperty
  a_chi_rsv: assert property (p_chi_rsv) else $error("reserved current bit accepted");

  property p_clo_ignored;
    REG_WR_I && (REG_ADDR_I == ADDR_CLO)
      |=> $stable(volt_code_ff) && $stable(curr_code_ff) && !WR_REJECT_O;
  endproperty
  a_clo_ignored: assert property (p_clo_ignored) else $error("08h write had effect");

  property p_two_byte;
    s_low_wr ##1 s_high_ok |=> VOLT_CODE_O[5:0] == $past(REG_WDATA_I[7:2], 2);
  endproperty
  a_two_byte: assert property (p_two_byte) else $error("low byte lost in pair");

endmodule

// [rtl/otl_pkg.sv]
// constants for the output voltage and current limit register bank
package otl_pkg;

  // ----------------------------------------------------------------
  // byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_VLO = 8'h06;
  localparam logic [7:0] ADDR_VHI = 8'h07;
  localparam logic [7:0] ADDR_CLO = 8'h08;
  localparam logic [7:0] ADDR_CHI = 8'h09;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int VOLT_CODE_W = 12;
  localparam int VOLT_HALF_W = 6;
  localparam int CURR_CODE_W = 7;
  localparam int VOLT_W = 20;
  localparam int CURR_MA_W = 13;
  localparam int VLO_CODE_LSB = 2;
  localparam logic [7:0] VHI_RSV_MASK = 8'hc0;
  localparam logic [7:0] CHI_RSV_MASK = 8'h80;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [VOLT_HALF_W-1:0] VOLT_HALF_RST = 6'h00;
  localparam logic [CURR_CODE_W-1:0] CURR_CODE_RST = 7'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // voltage scale, all in units of 0.1 mV
  // ----------------------------------------------------------------
  localparam logic [VOLT_W-1:0] VOLT_MIN_DMV = 20'h07530;
  localparam logic [VOLT_W-1:0] VOLT_MAX_DMV = 20'h32c80;
  localparam logic [VOLT_W-1:0] VOLT_OFFSET_DMV = 20'h03200;
  // bit 0 first: 8.1, 16, 33, 65, 130, 260, 521, 1041, 2082, 4164, 8328, 16656 mV
  localparam logic [VOLT_W-1:0] VOLT_WEIGHT_DMV [VOLT_CODE_W] = '{
    20'h00051, 20'h000a0, 20'h0014a, 20'h0028a, 20'h00514, 20'h00a28,
    20'h0145a, 20'h028aa, 20'h05154, 20'h0a2a8, 20'h14550, 20'h28aa0
  };

  // ----------------------------------------------------------------
  // current scale
  // ----------------------------------------------------------------
  localparam logic [CURR_MA_W-1:0] CURR_STEP_MA = 13'h0032;

endpackage

// [rtl/otl_volt_sum.sv]
// weighted sum of a voltage code plus the optional offset
`timescale 1ns/10ps
module otl_volt_sum
  import otl_pkg::*;
(
  // code in
  input wire logic [VOLT_CODE_W-1:0] code_i,
  input wire logic offset_dis_i,
  // effective level out, 0.1 mV units
  output logic [VOLT_W-1:0] dmv_o
);

  logic [VOLT_W-1:0] acc;

  always_comb
  begin
    acc = offset_dis_i ? '0 : VOLT_OFFSET_DMV;
    for (int i = 0; i < VOLT_CODE_W; i++)
    begin
      if (code_i[i])
      begin
        acc = acc + VOLT_WEIGHT_DMV[i];
      end
    end
    dmv_o = acc;
  end

endmodule

// [verification/otl_host_model.sv]
// host-side model of the byte register port
`timescale 1ns/10ps
module otl_host_model
(
  // clock
  input wire logic clk_i,
  // answers from the register bank
  input wire logic reject_i,
  input wire logic [7:0] rdata_i,
  // requests toward the register bank
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // one byte per call; q carries read data or the reject flag in bit 0
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk_i);
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(negedge clk_i);
    q = w ? {7'h00, reject_i} : rdata_i;
    wr_o = 1'b0;
    rd_o = 1'b0;
    // released lines show the inverse so a stale value never looks valid
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // two writes on consecutive edges; the strobe stays up between them
  task automatic wr_pair(input logic [7:0] a0, input logic [7:0] d0, input logic [7:0] a1,
                         input logic [7:0] d1, output logic [7:0] q0, output logic [7:0] q1);
    @(negedge clk_i);
    wr_o = 1'b1;
    rd_o = 1'b0;
    addr_o = a0;
    wdata_o = d0;
    @(negedge clk_i);
    q0 = {7'h00, reject_i};
    addr_o = a1;
    wdata_o = d1;
    @(negedge clk_i);
    q1 = {7'h00, reject_i};
    wr_o = 1'b0;
    addr_o = ~a1;
    wdata_o = ~d1;
  endtask
endmodule

// [verification/otl_otg_limit_regs_test.sv]
// self-checking bench for the output limit register bank
`timescale 1ns/10ps
module otl_otg_limit_regs_test
  import otl_pkg::*;
;
  logic clk, arst_n, wr, rd, off_dis, rej, off;
  logic [7:0] addr, wdata, rdata, q;
  logic [VOLT_CODE_W-1:0] vcode, code;
  logic [VOLT_W-1:0] vdmv;
  logic [CURR_CODE_W-1:0] ccode, cur;
  logic [CURR_MA_W-1:0] cma;
  logic [5:0] st_lo;
  int n_errors, n_compared;

  otl_otg_limit_regs uut (.CLK_I(clk), .ARST_N_I(arst_n), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .WR_REJECT_O(rej),
    .OFFSET_DIS_I(off_dis), .VOLT_CODE_O(vcode), .VOLT_DMV_O(vdmv), .CURR_CODE_O(ccode),
    .CURR_MA_O(cma));
  otl_host_model host (.clk_i(clk), .reject_i(rej), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  // ----------------------------------------------------------------
  // reference model and checks
  // ----------------------------------------------------------------
  function automatic int eff(input logic [11:0] c, input logic o);
    int s;
    s = o ? 0 : int'(VOLT_OFFSET_DMV);
    for (int i = 0; i < VOLT_CODE_W; i++)
    begin
      if (c[i])
        s += int'(VOLT_WEIGHT_DMV[i]);
    end
    return s;
  endfunction

  task automatic chk(input logic [19:0] got, input int exp, input string m);
    n_compared++;
    if (got !== 20'(exp))
    begin
      n_errors++;
      $display("FAIL %0t %s got %0d exp %0d", $time, m, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // voltage pair and current pair sequences
  // ----------------------------------------------------------------
  task automatic volt(input logic [7:0] lo, input logic [7:0] hi, input logic skip,
                      input logic o, input logic pair);
    logic [11:0] cand;
    logic ok;
    logic [7:0] q_lo;
    @(negedge clk);
    off_dis = o;
    off = o;
    @(negedge clk);
    @(negedge clk);
    chk(vdmv, eff(code, off), "level after offset change");
    if (!skip)
      st_lo = lo[7:2];
    cand = {hi[5:0], st_lo};
    ok = (hi & VHI_RSV_MASK) == 8'h00 && eff(cand, off) >= VOLT_MIN_DMV
         && eff(cand, off) <= VOLT_MAX_DMV;
    q_lo = 8'h00;
    // pair mode puts the two bytes on consecutive edges
    if (skip)
      host.xfer(1'b1, ADDR_VHI, hi, q);
    else if (pair)
      host.wr_pair(ADDR_VLO, lo, ADDR_VHI, hi, q_lo, q);
    else
    begin
      host.xfer(1'b1, ADDR_VLO, lo, q_lo);
      host.xfer(1'b1, ADDR_VHI, hi, q);
    end
    if (!skip)
      chk(q_lo, 0, "low byte reject");
    chk(q, !ok, "voltage reject");
    if (ok)
      code = cand;
    chk(vcode, code, "voltage code");
    @(negedge clk);
    chk(vdmv, eff(code, off), "voltage level");
    host.xfer(1'b0, ADDR_VLO, 8'h00, q);
    chk(q, {code[5:0], 2'b00}, "low byte read");
    host.xfer(1'b0, ADDR_VHI, 8'h00, q);
    chk(q, code[11:6], "high byte read");
  endtask

  task automatic curr(input logic [7:0] b, input logic [7:0] junk);
    host.xfer(1'b1, ADDR_CHI, b, q);
    chk(q, b[7], "current reject");
    if (!b[7])
      cur = b[6:0];
    chk(ccode, cur, "current code");
    @(negedge clk);
    chk(cma, cur * 50, "current limit");
    host.xfer(1'b1, ADDR_CLO, junk, q);
    chk(q, 0, "ignored byte reject");
    host.xfer(1'b0, ADDR_CLO, 8'h00, q);
    chk(q, 0, "ignored byte read");
    host.xfer(1'b0, ADDR_CHI, 8'h00, q);
    chk(q, cur, "current read");
  endtask

  // reset held for n cycles, released at a falling edge, then everything reads back as zero
  task automatic rst(input int n);
    arst_n = 1'b0;
    {st_lo, code, cur} = '0;
    repeat (n) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk(vdmv, eff(code, off), "level after reset");
    for (int a = 6; a <= 9; a++)
    begin
      host.xfer(1'b0, 8'(a), 8'h00, q);
      chk(q, 0, "reset read");
    end
    host.xfer(1'b0, 8'h3c, 8'h00, q);
    chk(q, 0, "unmapped read");
  endtask

  initial
  begin
    off_dis = 1'b0;
    arst_n = 1'b0;
    {off, st_lo, code, cur} = '0;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(32'h76ee5bc6));
    rst(16);
    $display("test reset done");
    // sweeps across the low and high edge of the accepted range
    for (int i = 0; i < 64; i++)
      volt({6'(i), 2'b11}, 8'h05, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 64; i++)
      volt({6'(i), 2'b10}, 8'h25, 1'b0, 1'b0, 1'b1);
    $display("test range edges done");
    rst(2);
    $display("test mid-run reset done");
    for (int i = 0; i < 60; i++)
    begin
      volt(8'($urandom), 8'($urandom) & ((($urandom % 4) == 0) ? 8'hff : 8'h3f),
           1'(($urandom % 4) == 0), 1'($urandom), 1'($urandom));
      curr(8'($urandom), 8'($urandom));
    end
    $display("test random traffic done");
    report_and_stop();
  end

  initial
  begin
    #100000;
    n_errors++;
    $display("FAIL %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule
